// ===== hw/pscr_defs.svh
// constants for the power stage configuration register bank
// Summary of operation
// - drive register bits 7:6 set predriver strength, 00 quarter to 11 full
// - drive register bits 5:4 set blanking time, larger code longer
// - drive register bits 3:0 each switch off one power transistor D..A
// - start-up bit 7 forces step-up, bit 6 forces step-down
// - start-up bits 5:4 pick switching frequency 5 to 1.25 MHz, reset 11
// - start-up bit 3 bypasses the soft-start sequence
// - start-up bit 2 picks small (0) or large (1) dead zone
// - speed-up bit 7 disable, bit 6 filter enable, bit 5 osc sense off
// - speed-up bits 4:0 set speed-up current in 250 nA steps
// - rail bits 2,1,0 power down high, mid and negative rails when 1
// - fuse setup bits 6:5 set fuse read current 2.5 to 4.0 mA
// - fuse setup bits 4:3 set fuse program current 40/50/60/35 mA
// - fuse setup bits 2:0 set program time 20,22,25,35,18,15,10,5 us
// - writing AAh to reset key gives a 16-cycle 12 MHz reset, self clears
// - the three key registers are write-only and reset to zero
// - first mask register bits mask matching bits of first alarm group
// - second mask register bits mask matching bits of second alarm group
`ifndef PSCR_DEFS_SVH
`define PSCR_DEFS_SVH

`define PSCR_ADDR_DRV     8'h2b
`define PSCR_ADDR_STRT    8'h2c
`define PSCR_ADDR_SPUP    8'h2d
`define PSCR_ADDR_RAIL    8'h2e
`define PSCR_ADDR_FUSE    8'h2f
`define PSCR_ADDR_SRST    8'h30
`define PSCR_ADDR_KEY0    8'h31
`define PSCR_ADDR_KEY1    8'h32
`define PSCR_ADDR_KEY2    8'h33
`define PSCR_ADDR_MASKA   8'h3a
`define PSCR_ADDR_MASKB   8'h3b
`define PSCR_ADDR_STAT    8'h3c

`define PSCR_RST_DRV      8'h00
`define PSCR_RST_STRT     8'h30
`define PSCR_RST_ZERO     8'h00

`define PSCR_KEY_SRST     8'haa
`define PSCR_KEY_FIRST    8'haf
`define PSCR_KEY_SECOND   8'hfa
`define PSCR_KEY_THIRD    8'h55

// the reset pulse length in cycles of the 12 MHz core clock
`define PSCR_SRST_CYCLES  5'h10
`define PSCR_SRST_CNT_W   5

// field positions
`define PSCR_STR_HI   7
`define PSCR_STR_LO   6
`define PSCR_BLK_HI   5
`define PSCR_BLK_LO   4
`define PSCR_DIS_HI   3
`define PSCR_UP_BIT   7
`define PSCR_DN_BIT   6
`define PSCR_FRQ_HI   5
`define PSCR_FRQ_LO   4
`define PSCR_BYP_BIT  3
`define PSCR_DZ_BIT   2
`define PSCR_SPD_BIT  7
`define PSCR_FLT_BIT  6
`define PSCR_OSC_BIT  5
`define PSCR_CUR_HI   4
`define PSCR_HI_BIT   2
`define PSCR_MID_BIT  1
`define PSCR_NEG_BIT  0
`define PSCR_RD_HI    6
`define PSCR_RD_LO    5
`define PSCR_WR_HI    4
`define PSCR_WR_LO    3
`define PSCR_TM_HI    2

`endif

// ===== hw/pscr_pkg.sv
// types shared by the power stage configuration register bank
package pscr_pkg;

  typedef enum logic [1:0] {
    PSCR_KEY_IDLE,
    PSCR_KEY_GOT1,
    PSCR_KEY_GOT2
  } pscr_key_e;

  typedef struct packed {
    logic [1:0] predriver_strength;
    logic [1:0] blank_time;
    logic [3:0] power_switch_disable;
  } pscr_drive_s;

  typedef struct packed {
    logic       force_step_up;
    logic       force_step_down;
    logic [1:0] switching_sel_a;
    logic       bypass_soft_start;
    logic       dead_zone_large;
  } pscr_conv_s;

  typedef struct packed {
    logic       speedup_disable;
    logic       speedup_filter_en;
    logic       osc_sense_disable;
    logic [4:0] speedup_current;
  } pscr_spup_s;

  typedef struct packed {
    logic       high_rail_powerdown;
    logic       mid_rail_powerdown;
    logic       negative_rail_powerdown;
  } pscr_rail_s;

  typedef struct packed {
    logic [1:0] read_current;
    logic [1:0] write_current;
    logic [2:0] fuse_program_time;
  } pscr_fuse_s;

endpackage

// ===== hw/pscr_reset_pulse.sv
// stretches a one-cycle soft reset request to a fixed length pulse
`timescale 1ns/10ps
`include "pscr_defs.svh"
module pscr_reset_pulse (
  // clock and reset
  input  wire logic clk_sys_i,
  input  wire logic reset_i,
  // request and pulse
  input  wire logic start_i,
  output logic      pulse_o
);

  logic [`PSCR_SRST_CNT_W-1:0] cnt_q;
  logic [`PSCR_SRST_CNT_W-1:0] cnt_d;

  always_comb begin
    cnt_d = cnt_q;
    if (start_i) begin
      cnt_d = `PSCR_SRST_CYCLES;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign pulse_o = (cnt_q != '0);

endmodule

// ===== hw/pscr_regs.sv
// register bank for the power stage configuration
//
// Implementation choice: the plain strobed port.
`timescale 1ns/10ps
`include "pscr_defs.svh"
module pscr_regs (
  // clock and reset
  input  wire logic               clk_sys_i,
  input  wire logic               reset_i,
  // register port
  input  wire logic [7:0]         addr_i,
  input  wire logic [7:0]         wdata_i,
  input  wire logic               wr_i,
  input  wire logic               rd_i,
  output logic      [7:0]         rdata_o,
  // alarm sources
  input  wire logic [7:0]         alarm_group_a_i,
  input  wire logic [7:0]         alarm_group_b_i,
  output logic      [7:0]         alarm_group_a_o,
  output logic      [7:0]         alarm_group_b_o,
  // control to the analogue stages
  output pscr_pkg::pscr_drive_s   drive_o,
  output pscr_pkg::pscr_conv_s    conv_o,
  output pscr_pkg::pscr_spup_s    spup_o,
  output pscr_pkg::pscr_rail_s    rail_o,
  output pscr_pkg::pscr_fuse_s    fuse_o,
  // soft reset and fuse programming
  output logic                    soft_reset_o,
  output logic                    fuse_program_o
);

  logic [7:0]          drv_q;
  logic [7:0]          drv_d;
  logic [7:0]          strt_q;
  logic [7:0]          strt_d;
  logic [7:0]          spup_q;
  logic [7:0]          spup_d;
  logic [7:0]          rail_q;
  logic [7:0]          rail_d;
  logic [7:0]          fuse_q;
  logic [7:0]          fuse_d;
  logic [7:0]          srst_q;
  logic [7:0]          srst_d;
  logic [7:0]          key0_q;
  logic [7:0]          key0_d;
  logic [7:0]          key1_q;
  logic [7:0]          key1_d;
  logic [7:0]          key2_q;
  logic [7:0]          key2_d;
  logic [7:0]          maska_q;
  logic [7:0]          maska_d;
  logic [7:0]          maskb_q;
  logic [7:0]          maskb_d;
  logic [7:0]          rdata_q;
  logic [7:0]          rdata_d;
  logic                prog_q;
  logic                prog_d;
  pscr_pkg::pscr_key_e key_q;
  pscr_pkg::pscr_key_e key_d;
  logic                srst_start;
  logic                srst_busy;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // register writes and self-clearing soft reset
  always_comb begin
    drv_d   = drv_q;
    strt_d  = strt_q;
    spup_d  = spup_q;
    rail_d  = rail_q;
    fuse_d  = fuse_q;
    srst_d  = srst_q;
    key0_d  = key0_q;
    key1_d  = key1_q;
    key2_d  = key2_q;
    maska_d = maska_q;
    maskb_d = maskb_q;
    srst_start = 1'b0;
    if (wr_i) begin
      if (hit(addr_i, `PSCR_ADDR_DRV))   drv_d   = wdata_i;
      if (hit(addr_i, `PSCR_ADDR_STRT))  strt_d  = wdata_i;
      if (hit(addr_i, `PSCR_ADDR_SPUP))  spup_d  = wdata_i;
      if (hit(addr_i, `PSCR_ADDR_RAIL))  rail_d  = wdata_i;
      if (hit(addr_i, `PSCR_ADDR_FUSE))  fuse_d  = wdata_i;
      if (hit(addr_i, `PSCR_ADDR_KEY0))  key0_d  = wdata_i;
      if (hit(addr_i, `PSCR_ADDR_KEY1))  key1_d  = wdata_i;
      if (hit(addr_i, `PSCR_ADDR_KEY2))  key2_d  = wdata_i;
      if (hit(addr_i, `PSCR_ADDR_MASKA)) maska_d = wdata_i;
      if (hit(addr_i, `PSCR_ADDR_MASKB)) maskb_d = wdata_i;
      if (hit(addr_i, `PSCR_ADDR_SRST) &&
          wdata_i == `PSCR_KEY_SRST) begin
        srst_d     = wdata_i;
        srst_start = 1'b1;
      end
      // other values leave no trace
    end
    // clears once the pulse ends
    if (!srst_start && !srst_busy && srst_q != `PSCR_RST_ZERO) begin
      srst_d = `PSCR_RST_ZERO;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      drv_q   <= `PSCR_RST_DRV;
      strt_q  <= `PSCR_RST_STRT;
      spup_q  <= `PSCR_RST_ZERO;
      rail_q  <= `PSCR_RST_ZERO;
      fuse_q  <= `PSCR_RST_ZERO;
      srst_q  <= `PSCR_RST_ZERO;
      key0_q  <= `PSCR_RST_ZERO;
      key1_q  <= `PSCR_RST_ZERO;
      key2_q  <= `PSCR_RST_ZERO;
      maska_q <= `PSCR_RST_ZERO;
      maskb_q <= `PSCR_RST_ZERO;
    end else begin
      drv_q   <= drv_d;
      strt_q  <= strt_d;
      spup_q  <= spup_d;
      rail_q  <= rail_d;
      fuse_q  <= fuse_d;
      srst_q  <= srst_d;
      key0_q  <= key0_d;
      key1_q  <= key1_d;
      key2_q  <= key2_d;
      maska_q <= maska_d;
      maskb_q <= maskb_d;
    end
  end

  pscr_reset_pulse u_reset_pulse (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .start_i   (srst_start),
    .pulse_o   (srst_busy)
  );

  // fuse unlock sequence; any stray key write restarts it
  always_comb begin
    key_d  = key_q;
    prog_d = 1'b0;
    if (wr_i) begin
      unique case (key_q)
        pscr_pkg::PSCR_KEY_IDLE: begin
          if (hit(addr_i, `PSCR_ADDR_KEY0) && wdata_i == `PSCR_KEY_FIRST)
            key_d = pscr_pkg::PSCR_KEY_GOT1;
        end
        pscr_pkg::PSCR_KEY_GOT1: begin
          if (hit(addr_i, `PSCR_ADDR_KEY1) && wdata_i == `PSCR_KEY_SECOND)
            key_d = pscr_pkg::PSCR_KEY_GOT2;
          else
            key_d = pscr_pkg::PSCR_KEY_IDLE;
        end
        pscr_pkg::PSCR_KEY_GOT2: begin
          key_d = pscr_pkg::PSCR_KEY_IDLE;
          if (hit(addr_i, `PSCR_ADDR_KEY2) && wdata_i == `PSCR_KEY_THIRD)
            prog_d = 1'b1;
        end
        default: key_d = pscr_pkg::PSCR_KEY_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      key_q  <= pscr_pkg::PSCR_KEY_IDLE;
      prog_q <= 1'b0;
    end else begin
      key_q  <= key_d;
      prog_q <= prog_d;
    end
  end

  // read mux; key registers are write-only and read zero
  always_comb begin
    rdata_d = `PSCR_RST_ZERO;
    if (rd_i) begin
      if (hit(addr_i, `PSCR_ADDR_DRV))   rdata_d = drv_q;
      if (hit(addr_i, `PSCR_ADDR_STRT))  rdata_d = strt_q;
      if (hit(addr_i, `PSCR_ADDR_SPUP))  rdata_d = spup_q;
      if (hit(addr_i, `PSCR_ADDR_RAIL))  rdata_d = rail_q;
      if (hit(addr_i, `PSCR_ADDR_FUSE))  rdata_d = fuse_q;
      if (hit(addr_i, `PSCR_ADDR_SRST))  rdata_d = srst_q;
      if (hit(addr_i, `PSCR_ADDR_MASKA)) rdata_d = maska_q;
      if (hit(addr_i, `PSCR_ADDR_MASKB)) rdata_d = maskb_q;
      if (hit(addr_i, `PSCR_ADDR_STAT))
        rdata_d = {5'h00, srst_busy, 2'(key_q)};
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      rdata_q <= `PSCR_RST_ZERO;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // field fan-out
  assign drive_o.predriver_strength =
    drv_q[`PSCR_STR_HI:`PSCR_STR_LO];
  assign drive_o.blank_time = drv_q[`PSCR_BLK_HI:`PSCR_BLK_LO];
  assign drive_o.power_switch_disable = drv_q[`PSCR_DIS_HI:0];
  assign conv_o.force_step_up     = strt_q[`PSCR_UP_BIT];
  assign conv_o.force_step_down   = strt_q[`PSCR_DN_BIT];
  assign conv_o.switching_sel_a   =
    strt_q[`PSCR_FRQ_HI:`PSCR_FRQ_LO];
  assign conv_o.bypass_soft_start = strt_q[`PSCR_BYP_BIT];
  assign conv_o.dead_zone_large   = strt_q[`PSCR_DZ_BIT];
  assign spup_o.speedup_disable   = spup_q[`PSCR_SPD_BIT];
  assign spup_o.speedup_filter_en = spup_q[`PSCR_FLT_BIT];
  assign spup_o.osc_sense_disable = spup_q[`PSCR_OSC_BIT];
  assign spup_o.speedup_current   = spup_q[`PSCR_CUR_HI:0];
  assign rail_o.high_rail_powerdown     = rail_q[`PSCR_HI_BIT];
  assign rail_o.mid_rail_powerdown      = rail_q[`PSCR_MID_BIT];
  assign rail_o.negative_rail_powerdown = rail_q[`PSCR_NEG_BIT];
  assign fuse_o.read_current  = fuse_q[`PSCR_RD_HI:`PSCR_RD_LO];
  assign fuse_o.write_current = fuse_q[`PSCR_WR_HI:`PSCR_WR_LO];
  assign fuse_o.fuse_program_time = fuse_q[`PSCR_TM_HI:0];
  // masked alarm bits never reach the alarm registers
  assign alarm_group_a_o = alarm_group_a_i & ~maska_q;
  assign alarm_group_b_o = alarm_group_b_i & ~maskb_q;
  assign soft_reset_o    = srst_busy;
  assign fuse_program_o  = prog_q;
  assign rdata_o         = rdata_q;

  // assertions
  sequence s_srst_key;
    wr_i && addr_i == `PSCR_ADDR_SRST && wdata_i == `PSCR_KEY_SRST;
  endsequence

  sequence s_key_seq;
    (wr_i && addr_i == `PSCR_ADDR_KEY0 && wdata_i == `PSCR_KEY_FIRST) ##1
    (wr_i && addr_i == `PSCR_ADDR_KEY1 && wdata_i == `PSCR_KEY_SECOND) ##1
    (wr_i && addr_i == `PSCR_ADDR_KEY2 && wdata_i == `PSCR_KEY_THIRD);
  endsequence

  chk_srst_len_16: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    s_srst_key |=> soft_reset_o [*8] ##1 soft_reset_o [*8] ##1 !soft_reset_o
  ) else $error("soft reset pulse length wrong");

  chk_srst_self_clear: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    $fell(soft_reset_o) && !wr_i |=> srst_q == `PSCR_RST_ZERO
  ) else $error("soft reset register not cleared");

  chk_srst_bad_val: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    wr_i && addr_i == `PSCR_ADDR_SRST && wdata_i != `PSCR_KEY_SRST &&
    !soft_reset_o |=> !soft_reset_o
  ) else $error("non-key value started a soft reset");

  chk_key_unlock: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    key_q == pscr_pkg::PSCR_KEY_IDLE ##0 s_key_seq |=> fuse_program_o
  ) else $error("key sequence did not start programming");

  chk_key_only: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    fuse_program_o |-> $past(key_q) == pscr_pkg::PSCR_KEY_GOT2 &&
                        $past(wdata_i) == `PSCR_KEY_THIRD
  ) else $error("programming without full key sequence");

  chk_key_wo_read: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    rd_i && addr_i >= `PSCR_ADDR_KEY0 && addr_i <= `PSCR_ADDR_KEY2
    |=> rdata_o == `PSCR_RST_ZERO
  ) else $error("key register read back data");

  chk_mask_a: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    wr_i && addr_i == `PSCR_ADDR_MASKA |=>
      (alarm_group_a_o & $past(wdata_i)) == 8'h00
  ) else $error("masked group a alarm passed");

  chk_mask_b: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    wr_i && addr_i == `PSCR_ADDR_MASKB |=>
      (alarm_group_b_o & $past(wdata_i)) == 8'h00
  ) else $error("masked group b alarm passed");

  chk_strt_switching_sel_a: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    wr_i && addr_i == `PSCR_ADDR_STRT |=>
      conv_o.switching_sel_a == $past(wdata_i[5:4]) &&
      conv_o.force_step_up == $past(wdata_i[7])
  ) else $error("start-up fields not updated");

  chk_read_drv: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    wr_i && addr_i == `PSCR_ADDR_DRV ##1 rd_i && addr_i == `PSCR_ADDR_DRV
    |=> rdata_o == $past(wdata_i, 2) &&
        drive_o.predriver_strength == rdata_o[7:6]
  ) else $error("drive register readback wrong");

endmodule

// ===== tb/pscr_testbench.sv
// self-checking bench for the power stage configuration register bank
`timescale 1ns/10ps
`include "pscr_defs.svh"
module testbench;
  logic                  clk_sys_i = 1'b0;
  logic                  reset_i   = 1'b1;
  logic [7:0]            addr_i    = 8'h00;
  logic [7:0]            wdata_i   = 8'h00;
  logic                  wr_i      = 1'b0;
  logic                  rd_i      = 1'b0;
  logic [7:0]            alarm_a   = 8'h00;
  logic [7:0]            alarm_b   = 8'h00;
  logic [7:0]            rdata_o;
  logic [7:0]            alarm_a_o;
  logic [7:0]            alarm_b_o;
  pscr_pkg::pscr_drive_s drive_o;
  pscr_pkg::pscr_conv_s  conv_o;
  pscr_pkg::pscr_spup_s  spup_o;
  pscr_pkg::pscr_rail_s  rail_o;
  pscr_pkg::pscr_fuse_s  fuse_o;
  logic                  soft_reset_o;
  logic                  fuse_program_o;
  int                    bad_count = 0;
  int                    compares  = 0;
  int                    seed      = 9572;
  int                    fuse_n    = 0;
  logic [7:0]            exp_q[$];
  logic [7:0]            all_a [0:10] = '{8'h2b, 8'h2c, 8'h2d, 8'h2e, 8'h2f,
    8'h30, 8'h31, 8'h32, 8'h33, 8'h3a, 8'h3b};
  logic [7:0]            rw_a [0:6] = '{8'h2b, 8'h2c, 8'h2d, 8'h2e, 8'h2f,
    8'h3a, 8'h3b};

  always #50 clk_sys_i = ~clk_sys_i;

  pscr_regs dut (
    .clk_sys_i       (clk_sys_i),
    .reset_i         (reset_i),
    .addr_i          (addr_i),
    .wdata_i         (wdata_i),
    .wr_i            (wr_i),
    .rd_i            (rd_i),
    .rdata_o         (rdata_o),
    .alarm_group_a_i (alarm_a),
    .alarm_group_b_i (alarm_b),
    .alarm_group_a_o (alarm_a_o),
    .alarm_group_b_o (alarm_b_o),
    .drive_o         (drive_o),
    .conv_o          (conv_o),
    .spup_o          (spup_o),
    .rail_o          (rail_o),
    .fuse_o          (fuse_o),
    .soft_reset_o    (soft_reset_o),
    .fuse_program_o  (fuse_program_o)
  );

  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string m);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_sys_i);
    wr_i    <= 1'b0;
  endtask

  // the expectation goes on the queue as the strobe goes out
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk_sys_i);
    rd_i   <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  always @(posedge clk_sys_i) begin
    if (rd_i === 1'b1) begin
      #1;
      if (exp_q.size() == 0) chk(rdata_o, ~rdata_o, "stray read");
      else chk(rdata_o, exp_q.pop_front(), "read data");
    end
  end

  always @(posedge clk_sys_i) begin
    if (fuse_program_o === 1'b1) fuse_n <= fuse_n + 1;
  end

  task automatic do_reset;
    @(posedge clk_sys_i);
    reset_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    reset_i <= 1'b0;
  endtask

  task automatic reset_values;
    foreach (all_a[i]) rd(all_a[i], (all_a[i] == 8'h2c) ? 8'h30 : 8'h00);
    rd(8'h00, 8'h00);
    rd(8'h40, 8'h00);
    #1 chk({6'h0, conv_o.switching_sel_a}, 8'h03, "switching_sel_a reset");
    $display("test reset values done");
  endtask

  // counts cycles with the soft reset high, starting the cycle after a write
  task automatic pulse_len(input int cyc, input logic [7:0] e);
    int n;
    n = 0;
    repeat (cyc) begin
      #1;
      if (soft_reset_o === 1'b1) n++;
      @(posedge clk_sys_i);
    end
    chk(n[7:0], e, "soft reset length");
  endtask

  task automatic keys(input logic [7:0] a0, d0, a1, d1, a2, d2,
                      input logic e);
    wr(a0, d0);
    wr(a1, d1);
    wr(a2, d2);
    #1 chk({7'h0, fuse_program_o}, {7'h0, e}, "fuse pulse");
  endtask

  task automatic results;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    #2000000;
    bad_count++;
    $display("unexpected at %0t: run did not finish", $time);
    results();
  end

  initial begin
    logic [7:0] v;
    logic [7:0] ma;
    logic [7:0] mb;
    do_reset();
    reset_values();
    foreach (rw_a[i]) begin
      v = $random(seed);
      wr(rw_a[i], v);
      #1;
      case (rw_a[i])
        8'h2b: chk(drive_o, v, "drive");
        8'h2c: chk({2'h0, conv_o}, {2'h0, v[7:2]}, "conv");
        8'h2d: chk(spup_o, v, "speedup");
        8'h2e: chk({5'h0, rail_o}, {5'h0, v[2:0]}, "rail");
        8'h2f: chk({1'h0, fuse_o}, {1'h0, v[6:0]}, "fuse");
        default: ;
      endcase
      rd(rw_a[i], v);
    end
    wr(8'h40, 8'hff);
    rd(8'h40, 8'h00);
    $display("test read write done");
    ma = $random(seed);
    mb = $random(seed);
    wr(8'h3a, ma);
    wr(8'h3b, mb);
    repeat (6) begin
      @(posedge clk_sys_i);
      alarm_a <= $random(seed);
      alarm_b <= $random(seed);
      #1 chk(alarm_a_o, alarm_a & ~ma, "alarm a");
      chk(alarm_b_o, alarm_b & ~mb, "alarm b");
    end
    $display("test alarm masks done");
    do_reset();
    reset_values();
    wr(8'h30, 8'h55);
    pulse_len(20, 8'h00);
    rd(8'h30, 8'h00);
    wr(8'h30, 8'haa);
    pulse_len(24, 8'h10);
    rd(8'h30, 8'h00);
    $display("test soft reset done");
    keys(8'h31, 8'haf, 8'h32, 8'hfa, 8'h33, 8'h55, 1'b1);
    keys(8'h31, 8'haf, 8'h32, 8'hfb, 8'h33, 8'h55, 1'b0);
    keys(8'h32, 8'hfa, 8'h31, 8'haf, 8'h33, 8'h55, 1'b0);
    wr(8'h31, 8'haf);
    wr(8'h32, 8'hfa);
    wr(8'h2b, 8'h00);
    wr(8'h33, 8'h55);
    #1 chk({7'h0, fuse_program_o}, 8'h00, "aborted key");
    keys(8'h31, 8'haf, 8'h32, 8'hfa, 8'h33, 8'h55, 1'b1);
    rd(8'h31, 8'h00);
    rd(8'h32, 8'h00);
    rd(8'h33, 8'h00);
    repeat (3) @(posedge clk_sys_i);
    chk(fuse_n[7:0], 8'h02, "fuse pulse count");
    $display("test fuse keys done");
    // bounded wait for the monitor to drain the queue
    for (int i = 0; i < 10 && exp_q.size() != 0; i++) @(posedge clk_sys_i);
    if (exp_q.size() != 0) begin
      bad_count++;
      $display("unexpected at %0t: reads left unanswered", $time);
    end
    results();
  end
endmodule
